// [icpf_pkg.sv]
// Constants and types for the isolated converter protection sequencer
package icpf_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int LOW_TIME_US = 150;
    localparam int LOW_TIME_CYC = LOW_TIME_US * CLK_MHZ;
    localparam int SS_STEP_US = 128;
    localparam int SS_STEPS = 7;
    localparam int SS_CYC = SS_STEP_US * SS_STEPS * CLK_MHZ;
    localparam int DEGLITCH_US = 3000;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int CNT_W = 17;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] CAUSE_OFS = 4'h8;
    localparam int CTRL_PERMIT_BIT = 0;
    localparam logic CTRL_PERMIT_RESET = 1'b1;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_SWITCH_BIT = 4;
    localparam int STATUS_GOOD_BIT = 5;
    localparam int STATUS_PIN_BIT = 6;
    localparam int STATUS_REQ_BIT = 7;
    localparam int STATUS_LOWLONG_BIT = 8;

    // Latched fault causes
    localparam int CAUSE_UV_MAIN = 0;
    localparam int CAUSE_UV_AUX = 1;
    localparam int CAUSE_OV_MAIN = 2;
    localparam int CAUSE_OV_AUX = 3;
    localparam int CAUSE_FAILSAFE = 4;
    localparam int CAUSE_HEAT_PRI = 5;
    localparam int CAUSE_HEAT_SEC = 6;
    localparam int CAUSE_W = 7;

    // Positions in the synchronised input vector
    localparam int IN_REQ = 0;
    localparam int IN_SUP_RESET = 1;
    localparam int IN_SUP_LOW = 2;
    localparam int IN_SUP_HIGH = 3;
    localparam int IN_UV_MAIN = 4;
    localparam int IN_UV_AUX = 5;
    localparam int IN_OV_MAIN = 6;
    localparam int IN_OV_AUX = 7;
    localparam int IN_FAILSAFE = 8;
    localparam int IN_HEAT_PRI = 9;
    localparam int IN_HEAT_SEC = 10;
    localparam int IN_PIN = 11;
    localparam int IN_W = 12;

    typedef enum logic [2:0] {
        ST_AUTO_LOCK,
        ST_DISABLED,
        ST_SOFT_START,
        ST_RUN,
        ST_LATCHED
    } icpf_state_type;

endpackage

// [icpf_sync.sv]
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
module icpf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

// [icpf_top.sv]
// Enable, output-good and fault-protection sequencer for an isolated converter
`timescale 1ns/100ps
module icpf_top #(
    parameter int LOW_TIME_CYC = icpf_pkg::LOW_TIME_CYC,
    parameter int SS_CYC = icpf_pkg::SS_CYC,
    parameter int DEGLITCH_CYC = icpf_pkg::DEGLITCH_CYC
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Host turn-on request pin
    input wire logic turn_on_request_i,
    // Supply comparators, hysteretic
    input wire logic supply_reset_i,
    input wire logic supply_low_i,
    input wire logic supply_high_i,
    // Feedback comparators, hysteretic
    input wire logic main_feedback_sense_low_i,
    input wire logic aux_feedback_sense_low_i,
    input wire logic main_feedback_sense_high_i,
    input wire logic aux_feedback_sense_high_i,
    input wire logic failsafe_rail_high_i,
    // Heat comparators, high until below recovery
    input wire logic primary_heat_limit_i,
    input wire logic secondary_heat_limit_i,
    // Open-drain output-good pin
    input wire logic output_good_flag_in_i,
    output logic output_good_flag_out_o,
    output logic output_good_flag_oe_o,
    // Converter control
    output logic switch_enable_o,
    output logic soft_start_o,
    output logic latched_off_o,
    // Register port
    input wire logic [icpf_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);

    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [icpf_pkg::IN_W-1:0] raw_in;
    logic [icpf_pkg::IN_W-1:0] sync_in;

    assign raw_in = {
        output_good_flag_in_i,
        secondary_heat_limit_i,
        primary_heat_limit_i,
        failsafe_rail_high_i,
        aux_feedback_sense_high_i,
        main_feedback_sense_high_i,
        aux_feedback_sense_low_i,
        main_feedback_sense_low_i,
        supply_high_i,
        supply_low_i,
        supply_reset_i,
        turn_on_request_i
    };

    icpf_sync #(
        .WIDTH(icpf_pkg::IN_W)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i(raw_in),
        .sync_o(sync_in)
    );

    logic req_s;
    logic sup_reset_s;
    logic sup_low_s;
    logic sup_high_s;
    logic uv_main_s;
    logic uv_aux_s;
    logic ov_main_s;
    logic ov_aux_s;
    logic failsafe_s;
    logic heat_pri_s;
    logic heat_sec_s;
    logic pin_s;

    assign req_s = sync_in[icpf_pkg::IN_REQ];
    assign sup_reset_s = sync_in[icpf_pkg::IN_SUP_RESET];
    assign sup_low_s = sync_in[icpf_pkg::IN_SUP_LOW];
    assign sup_high_s = sync_in[icpf_pkg::IN_SUP_HIGH];
    assign uv_main_s = sync_in[icpf_pkg::IN_UV_MAIN];
    assign uv_aux_s = sync_in[icpf_pkg::IN_UV_AUX];
    assign ov_main_s = sync_in[icpf_pkg::IN_OV_MAIN];
    assign ov_aux_s = sync_in[icpf_pkg::IN_OV_AUX];
    assign failsafe_s = sync_in[icpf_pkg::IN_FAILSAFE];
    assign heat_pri_s = sync_in[icpf_pkg::IN_HEAT_PRI];
    assign heat_sec_s = sync_in[icpf_pkg::IN_HEAT_SEC];
    assign pin_s = sync_in[icpf_pkg::IN_PIN];

    // ****************************************
    // Control register
    // ****************************************
    logic permit_reg;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            permit_reg <= icpf_pkg::CTRL_PERMIT_RESET;
        end else if (reg_wr_i && reg_addr_i == icpf_pkg::CTRL_OFS) begin
            permit_reg <= reg_wdata_i[icpf_pkg::CTRL_PERMIT_BIT];
        end
    end

    // Software can hold the converter off as if the request were low
    logic req_eff;
    assign req_eff = req_s && permit_reg;

    // ****************************************
    // Fault terms
    // ****************************************
    // Overvoltage, fail-safe and heat act in soft-start too
    logic hard_fault;
    logic uv_fault;
    logic any_fault;
    assign hard_fault = ov_main_s | ov_aux_s | failsafe_s | heat_pri_s | heat_sec_s;
    assign uv_fault = uv_main_s | uv_aux_s;
    assign any_fault = hard_fault | uv_fault;

    // ****************************************
    // Request low-time measurement
    // ****************************************
    logic [icpf_pkg::CNT_W-1:0] low_cnt_reg;
    logic low_long;

    assign low_long = low_cnt_reg == icpf_pkg::CNT_W'(LOW_TIME_CYC);

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            low_cnt_reg <= '0;
        end else if (req_eff) begin
            low_cnt_reg <= '0;
        end else if (!low_long) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // ****************************************
    // State machine
    // ****************************************
    icpf_pkg::icpf_state_type state_reg;
    icpf_pkg::icpf_state_type state_next;
    logic [icpf_pkg::CNT_W-1:0] ss_cnt_reg;
    logic ss_done;
    logic [icpf_pkg::CAUSE_W-1:0] cause_reg;
    logic [icpf_pkg::CAUSE_W-1:0] cause_set;
    logic fault_take;

    assign ss_done = ss_cnt_reg == icpf_pkg::CNT_W'(SS_CYC - 1);

    // Faults seen in the current switching state
    always_comb begin
        cause_set = '0;
        if (state_reg == icpf_pkg::ST_SOFT_START || state_reg == icpf_pkg::ST_RUN) begin
            cause_set[icpf_pkg::CAUSE_OV_MAIN] = ov_main_s;
            cause_set[icpf_pkg::CAUSE_OV_AUX] = ov_aux_s;
            cause_set[icpf_pkg::CAUSE_FAILSAFE] = failsafe_s;
            cause_set[icpf_pkg::CAUSE_HEAT_PRI] = heat_pri_s;
            cause_set[icpf_pkg::CAUSE_HEAT_SEC] = heat_sec_s;
            // Undervoltage only counts from the last soft-start cycle (ss_done) on
            if (state_reg == icpf_pkg::ST_RUN || ss_done) begin
                cause_set[icpf_pkg::CAUSE_UV_MAIN] = uv_main_s;
                cause_set[icpf_pkg::CAUSE_UV_AUX] = uv_aux_s;
            end
        end
    end

    assign fault_take = |cause_set;

    always_comb begin
        state_next = state_reg;
        if (sup_reset_s) begin
            // Reset level drops every protection, latched ones too
            state_next = icpf_pkg::ST_AUTO_LOCK;
        end else begin
            unique case (state_reg)
                icpf_pkg::ST_AUTO_LOCK: begin
                    if (!sup_low_s && !sup_high_s) begin
                        if (req_eff) begin
                            state_next = icpf_pkg::ST_SOFT_START;
                        end else begin
                            state_next = icpf_pkg::ST_DISABLED;
                        end
                    end
                end
                icpf_pkg::ST_DISABLED: begin
                    if (sup_low_s || sup_high_s) begin
                        state_next = icpf_pkg::ST_AUTO_LOCK;
                    end else if (req_eff) begin
                        state_next = icpf_pkg::ST_SOFT_START;
                    end
                end
                icpf_pkg::ST_SOFT_START, icpf_pkg::ST_RUN: begin
                    if (fault_take) begin
                        state_next = icpf_pkg::ST_LATCHED;
                    end else if (sup_low_s || sup_high_s) begin
                        state_next = icpf_pkg::ST_AUTO_LOCK;
                    end else if (!req_eff) begin
                        state_next = icpf_pkg::ST_DISABLED;
                    end else if (state_reg == icpf_pkg::ST_SOFT_START && ss_done) begin
                        state_next = icpf_pkg::ST_RUN;
                    end
                end
                icpf_pkg::ST_LATCHED: begin
                    // Supply lockouts pass by without touching the latch
                    if (req_eff && low_long && !any_fault && !sup_low_s && !sup_high_s) begin
                        state_next = icpf_pkg::ST_SOFT_START;
                    end
                end
                default: begin
                    state_next = icpf_pkg::ST_AUTO_LOCK;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_reg <= icpf_pkg::ST_AUTO_LOCK;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Soft-start timer
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ss_cnt_reg <= '0;
        end else if (state_reg == icpf_pkg::ST_SOFT_START && !ss_done) begin
            ss_cnt_reg <= ss_cnt_reg + 1'b1;
        end else begin
            ss_cnt_reg <= '0;
        end
    end

    // ****************************************
    // Fault cause record
    // ****************************************
    // Cleared when the latch is released or the supply reset level is seen, never while a set is pending
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cause_reg <= '0;
        end else if (fault_take) begin
            cause_reg <= cause_reg | cause_set;
        end else if (sup_reset_s) begin
            cause_reg <= '0;
        end else if (state_reg == icpf_pkg::ST_LATCHED && state_next == icpf_pkg::ST_SOFT_START) begin
            cause_reg <= '0;
        end
    end

    // ****************************************
    // Start-up deglitch of the good flag
    // ****************************************
    logic [icpf_pkg::CNT_W-1:0] dg_cnt_reg;
    logic armed_reg;

    // Applied once per start, so regulation ripple later cannot stall the flag
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            dg_cnt_reg <= '0;
            armed_reg <= 1'b0;
        end else if (state_reg != icpf_pkg::ST_RUN) begin
            dg_cnt_reg <= '0;
            armed_reg <= 1'b0;
        end else if (!armed_reg) begin
            if (dg_cnt_reg == icpf_pkg::CNT_W'(DEGLITCH_CYC - 1)) begin
                armed_reg <= 1'b1;
            end else begin
                dg_cnt_reg <= dg_cnt_reg + 1'b1;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic switch_reg;
    logic soft_reg;
    logic latched_reg;
    logic good_reg;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            switch_reg <= 1'b0;
            soft_reg <= 1'b0;
            latched_reg <= 1'b0;
        end else begin
            switch_reg <= state_next == icpf_pkg::ST_SOFT_START || state_next == icpf_pkg::ST_RUN;
            soft_reg <= state_next == icpf_pkg::ST_SOFT_START;
            latched_reg <= state_next == icpf_pkg::ST_LATCHED;
        end
    end

    // Comparator bands sit at the output tolerance window
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            good_reg <= 1'b0;
        end else begin
            good_reg <= state_reg == icpf_pkg::ST_RUN && state_next == icpf_pkg::ST_RUN
                && armed_reg && !any_fault;
        end
    end

    assign switch_enable_o = switch_reg;
    assign soft_start_o = soft_reg;
    assign latched_off_o = latched_reg;
    assign output_good_flag_out_o = 1'b0;
    assign output_good_flag_oe_o = good_reg;

    // ****************************************
    // Register read
    // ****************************************
    logic [31:0] rdata_reg;
    logic [31:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[icpf_pkg::STATUS_STATE_LSB +: 3] = state_reg;
        status_word[icpf_pkg::STATUS_SWITCH_BIT] = switch_reg;
        status_word[icpf_pkg::STATUS_GOOD_BIT] = good_reg;
        status_word[icpf_pkg::STATUS_PIN_BIT] = pin_s;
        status_word[icpf_pkg::STATUS_REQ_BIT] = req_s;
        status_word[icpf_pkg::STATUS_LOWLONG_BIT] = low_long;
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                icpf_pkg::CTRL_OFS: begin
                    rdata_reg <= {31'h0, permit_reg};
                end
                icpf_pkg::STATUS_OFS: begin
                    rdata_reg <= status_word;
                end
                icpf_pkg::CAUSE_OFS: begin
                    rdata_reg <= {25'h0, cause_reg};
                end
                default: begin
                    rdata_reg <= '0;
                end
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule

// [icpf_top_asserts.sv]
// Port-level assertions for the protection sequencer
`timescale 1ns/100ps
module icpf_checker #(
    parameter int LOW_TIME_CYC = icpf_pkg::LOW_TIME_CYC,
    parameter int SS_CYC = icpf_pkg::SS_CYC,
    parameter int DEGLITCH_CYC = icpf_pkg::DEGLITCH_CYC
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic turn_on_request_i,
    input wire logic supply_reset_i,
    input wire logic supply_low_i,
    input wire logic supply_high_i,
    input wire logic main_feedback_sense_low_i,
    input wire logic aux_feedback_sense_low_i,
    input wire logic main_feedback_sense_high_i,
    input wire logic aux_feedback_sense_high_i,
    input wire logic failsafe_rail_high_i,
    input wire logic primary_heat_limit_i,
    input wire logic secondary_heat_limit_i,
    input wire logic output_good_flag_oe_o,
    input wire logic switch_enable_o,
    input wire logic soft_start_o,
    input wire logic latched_off_o
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic trip_w;
    logic stop_w;
    logic rel_ok_reg;
    int low_run_reg;
    int ss_run_reg;
    int run_run_reg;
    assign trip_w = main_feedback_sense_high_i | aux_feedback_sense_high_i | failsafe_rail_high_i
        | primary_heat_limit_i | secondary_heat_limit_i;
    assign stop_w = trip_w | ~turn_on_request_i | supply_reset_i | supply_low_i | supply_high_i;
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || turn_on_request_i) low_run_reg <= 0;
        else if (low_run_reg < LOW_TIME_CYC) low_run_reg <= low_run_reg + 1;
    end
    // One cycle of slack on the low count: the exact compare edge is the design's choice
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || !latched_off_o) rel_ok_reg <= 1'b0;
        else if (supply_reset_i || low_run_reg >= LOW_TIME_CYC - 1) rel_ok_reg <= 1'b1;
    end
    always_ff @(posedge core_clk_i) begin
        ss_run_reg <= soft_start_o ? ss_run_reg + 1 : 0;
        run_run_reg <= (switch_enable_o && !soft_start_o) ? run_run_reg + 1 : 0;
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_quiet;
        latched_off_o |-> !switch_enable_o && !output_good_flag_oe_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("active while latched");
    property p_good_run;
        output_good_flag_oe_o |-> switch_enable_o && !soft_start_o;
    endproperty
    a_good_run: assert property (p_good_run) else $error("good flag outside run");
    property p_stop;
        switch_enable_o && stop_w |-> ##[1:4] !switch_enable_o;
    endproperty
    a_stop: assert property (p_stop) else $error("switching not stopped");
    property p_trip;
        switch_enable_o && trip_w && !supply_reset_i |-> ##[1:4] latched_off_o;
    endproperty
    a_trip: assert property (p_trip) else $error("fault did not latch");
    property p_good_drop;
        output_good_flag_oe_o && (stop_w || main_feedback_sense_low_i || aux_feedback_sense_low_i)
            |-> ##[1:4] !output_good_flag_oe_o;
    endproperty
    a_good_drop: assert property (p_good_drop) else $error("good flag not released");
    property p_release;
        $fell(latched_off_o) |-> rel_ok_reg;
    endproperty
    a_release: assert property (p_release) else $error("latch left early");
    property p_ss_len;
        $fell(soft_start_o) && switch_enable_o |-> ss_run_reg >= SS_CYC && ss_run_reg <= SS_CYC + 2;
    endproperty
    a_ss_len: assert property (p_ss_len) else $error("soft-start length wrong");
    property p_deglitch;
        $rose(output_good_flag_oe_o) |-> run_run_reg >= DEGLITCH_CYC - 1;
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("good flag too early");
    c_good: cover property ($rose(output_good_flag_oe_o));
    c_latch: cover property ($rose(latched_off_o));
    c_release: cover property ($fell(latched_off_o));
endmodule

bind icpf_top icpf_checker #(
    .LOW_TIME_CYC(LOW_TIME_CYC),
    .SS_CYC(SS_CYC),
    .DEGLITCH_CYC(DEGLITCH_CYC)
) u_chk (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .turn_on_request_i(turn_on_request_i),
    .supply_reset_i(supply_reset_i),
    .supply_low_i(supply_low_i),
    .supply_high_i(supply_high_i),
    .main_feedback_sense_low_i(main_feedback_sense_low_i),
    .aux_feedback_sense_low_i(aux_feedback_sense_low_i),
    .main_feedback_sense_high_i(main_feedback_sense_high_i),
    .aux_feedback_sense_high_i(aux_feedback_sense_high_i),
    .failsafe_rail_high_i(failsafe_rail_high_i),
    .primary_heat_limit_i(primary_heat_limit_i),
    .secondary_heat_limit_i(secondary_heat_limit_i),
    .output_good_flag_oe_o(output_good_flag_oe_o),
    .switch_enable_o(switch_enable_o),
    .soft_start_o(soft_start_o),
    .latched_off_o(latched_off_o)
);

// [icpf_host.sv]
// Host model: drives the turn-on request and pulls up the output-good pin
`timescale 1ns/100ps
module icpf_host #(
    parameter int MIN_LOW_CYC = 8
) (
    input wire logic core_clk_i,
    input wire logic want_on_i,
    input wire logic short_low_i,
    input wire logic good_out_i,
    input wire logic good_oe_i,
    output logic turn_on_request_o,
    output logic good_pin_o
);
    int low_cnt = 0;
    initial turn_on_request_o = 1'b0;
    // Pull-up wins whenever the open-drain stage lets go
    assign good_pin_o = good_oe_i ? good_out_i : 1'b1;
    // A lowered request stays low past the minimum unless a short toggle is ordered
    always @(posedge core_clk_i) begin
        low_cnt <= turn_on_request_o ? 0 : low_cnt + 1;
        if (!want_on_i) turn_on_request_o <= 1'b0;
        else if (short_low_i || low_cnt > MIN_LOW_CYC) turn_on_request_o <= 1'b1;
    end
endmodule

// [test_isolated_converter_protection_fsm.sv]
// Self-checking testbench of the protection sequencer
`timescale 1ns/100ps
module test_isolated_converter_protection_fsm;
    localparam int LT = 8;
    localparam int SW = 0;
    localparam int SOFT = 1;
    localparam int LAT = 2;
    localparam int GOOD = 3;
    localparam logic [3:0] STAT = icpf_pkg::STATUS_OFS;
    localparam logic [3:0] CAUSE = icpf_pkg::CAUSE_OFS;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic want_on = 1'b0;
    logic short_low = 1'b0;
    logic sup_rst = 1'b0;
    logic sup_low = 1'b0;
    logic sup_high = 1'b0;
    logic [6:0] flt = 7'h00;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    wire [3:0] outs;
    logic req;
    logic pin;
    logic good_out;
    int fails = 0;
    int checks_done = 0;
    initial forever #12.5 core_clk_i = ~core_clk_i;
    icpf_top #(.LOW_TIME_CYC(LT), .SS_CYC(16), .DEGLITCH_CYC(10)) DUT (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .turn_on_request_i(req),
        .supply_reset_i(sup_rst), .supply_low_i(sup_low), .supply_high_i(sup_high),
        .main_feedback_sense_low_i(flt[0]), .aux_feedback_sense_low_i(flt[1]),
        .main_feedback_sense_high_i(flt[2]), .aux_feedback_sense_high_i(flt[3]),
        .failsafe_rail_high_i(flt[4]), .primary_heat_limit_i(flt[5]), .secondary_heat_limit_i(flt[6]),
        .output_good_flag_in_i(pin), .output_good_flag_out_o(good_out), .output_good_flag_oe_o(outs[GOOD]),
        .switch_enable_o(outs[SW]), .soft_start_o(outs[SOFT]), .latched_off_o(outs[LAT]),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata)
    );
    icpf_host #(.MIN_LOW_CYC(LT)) u_host (
        .core_clk_i(core_clk_i), .want_on_i(want_on), .short_low_i(short_low),
        .good_out_i(good_out), .good_oe_i(outs[GOOD]), .turn_on_request_o(req), .good_pin_o(pin)
    );
    task automatic final_report();
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bounded wait on one output; running out counts as a mismatch
    task automatic wait_for(input int k, input logic v);
        int i;
        i = 0;
        @(negedge core_clk_i);
        while (outs[k] !== v && i < 200) begin
            @(negedge core_clk_i);
            i++;
        end
        check("output level", {31'h0, v}, {31'h0, outs[k]});
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(negedge core_clk_i);
        check("register", e, rdata & m);
    endtask
    task automatic start();
        @(posedge core_clk_i);
        want_on <= 1'b1;
        wait_for(SOFT, 1'b1);
        check("switching", 32'h1, {31'h0, outs[SW]});
        wait_for(GOOD, 1'b1);
        check("good pin", 32'h0, {31'h0, pin});
        reg_check(STAT, 32'h1bf, 32'hb3);
    endtask
    task automatic stop();
        @(posedge core_clk_i);
        want_on <= 1'b0;
        wait_for(SW, 1'b0);
        check("good pin", 32'h1, {31'h0, pin});
    endtask
    task automatic t_regs();
        repeat (4) @(posedge core_clk_i);
        reg_check(icpf_pkg::CTRL_OFS, 32'h1, 32'h1);
        reg_check(CAUSE, 32'h7f, 32'h0);
        reg_check(4'hc, 32'hffffffff, 32'h0);
        @(negedge core_clk_i);
        check("read idle", 32'h0, rdata);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= CAUSE;
        wdata <= 32'h7f;
        @(posedge core_clk_i);
        addr <= icpf_pkg::CTRL_OFS;
        wdata <= 32'h0;
        @(posedge core_clk_i);
        wr <= 1'b0;
        reg_check(icpf_pkg::CTRL_OFS, 32'h1, 32'h0);
        reg_check(CAUSE, 32'h7f, 32'h0);
        reg_check(STAT, 32'h7, 32'(icpf_pkg::ST_DISABLED));
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= icpf_pkg::CTRL_OFS;
        wdata <= 32'h1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic t_faults();
        for (int k = 0; k < 7; k++) begin
            start();
            @(posedge core_clk_i);
            flt <= 7'(1 << k);
            wait_for(LAT, 1'b1);
            check("good pin", 32'h1, {31'h0, pin});
            reg_check(CAUSE, 32'h7f, 32'(1 << k));
            @(posedge core_clk_i);
            flt <= 7'h00;
            short_low <= 1'b1;
            want_on <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            want_on <= 1'b1;
            repeat (12) @(negedge core_clk_i);
            check("latched", 32'h1, {31'h0, outs[LAT]});
            @(posedge core_clk_i);
            short_low <= 1'b0;
            want_on <= 1'b0;
            @(posedge core_clk_i);
            want_on <= 1'b1;
            wait_for(SOFT, 1'b1);
            reg_check(CAUSE, 32'h7f, 32'h0);
            stop();
        end
    endtask
    task automatic t_ss_uv();
        @(posedge core_clk_i);
        flt <= 7'h01;
        want_on <= 1'b1;
        wait_for(SOFT, 1'b1);
        repeat (8) @(negedge core_clk_i);
        check("latched", 32'h0, {31'h0, outs[LAT]});
        wait_for(LAT, 1'b1);
        @(posedge core_clk_i);
        flt <= 7'h00;
        sup_rst <= 1'b1;
        wait_for(LAT, 1'b0);
        reg_check(CAUSE, 32'h7f, 32'h0);
        reg_check(STAT, 32'h7, 32'(icpf_pkg::ST_AUTO_LOCK));
        @(posedge core_clk_i);
        sup_rst <= 1'b0;
        wait_for(SOFT, 1'b1);
        stop();
    endtask
    task automatic t_supply();
        start();
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk_i);
            sup_low <= (k == 0);
            sup_high <= (k == 1);
            wait_for(SW, 1'b0);
            reg_check(STAT, 32'h7, 32'(icpf_pkg::ST_AUTO_LOCK));
            @(posedge core_clk_i);
            sup_low <= 1'b0;
            sup_high <= 1'b0;
            wait_for(GOOD, 1'b1);
        end
        @(posedge core_clk_i);
        flt <= 7'h04;
        wait_for(LAT, 1'b1);
        @(posedge core_clk_i);
        flt <= 7'h00;
        sup_high <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        sup_high <= 1'b0;
        repeat (8) @(negedge core_clk_i);
        check("latched", 32'h1, {31'h0, outs[LAT]});
        @(posedge core_clk_i);
        sup_rst <= 1'b1;
        want_on <= 1'b0;
        wait_for(LAT, 1'b0);
        @(posedge core_clk_i);
        sup_rst <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        reg_check(STAT, 32'h7, 32'(icpf_pkg::ST_DISABLED));
    endtask
    initial begin
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_faults();
        t_ss_uv();
        t_supply();
        final_report();
    end
    // Full run takes under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        final_report();
    end
endmodule
